// *** core/clock_ctrl_pkg.sv ***
// shared constants, types and register map of the clock source and start-up controller
package clock_ctrl_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] ADDR_OPTION_STATUS = 8'h00;
  localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CLOCK_STATUS = 8'h08;
  localparam logic [7:0] ADDR_WAKE_FLAGS = 8'h0c;

  // sleep control fields
  localparam int SLEEP_MODE_LSB = 0;
  localparam int SLEEP_ENABLE_BIT = 2;
  localparam int SLEEP_GO_BIT = 8;

  // clock status fields
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_GATE_LSB = 8;
  localparam int STATUS_ASYNC_ARM_BIT = 11;
  localparam int STATUS_RESERVED_START_BIT = 12;
  localparam int STATUS_SOURCE_LSB = 16;

  // wake flag fields
  localparam int WAKE_EXT_INT_BIT = 0;
  localparam int WAKE_SERIAL_START_BIT = 1;

  // start-up counts in cycles of the selected source
  localparam logic [16:0] STARTUP_SHORT_CK = 17'h00006;
  localparam logic [16:0] STARTUP_258_CK = 17'h00102;
  localparam logic [16:0] STARTUP_1K_CK = 17'h00400;
  localparam logic [16:0] RESET_EXTRA_CK = 17'h0000e;
  localparam int STARTUP_16K_CK_DEFAULT = 16384;

  // reset delays in watchdog oscillator cycles (nominal 4.1 ms and 65 ms)
  localparam int WDT_SHORT_CYCLES_DEFAULT = 4096;
  localparam int WDT_LONG_CYCLES_DEFAULT = 65536;

  // division factor of the divide-by-eight option, minus one
  localparam logic [2:0] DIV8_LAST = 3'h7;

  // option bits: a one is unprogrammed, a zero is programmed
  typedef struct packed {
    logic divide_by_eight_option;
    logic [1:0] startup_time_select;
    logic [3:0] clock_source_select;
  } option_t;

  // option setting as delivered: rc source, longest start-up, divide by eight programmed
  localparam option_t DELIVERED_OPTIONS = '{1'b0, 2'b10, 4'h2};

  // selected clock source
  typedef enum logic [2:0] {
    SRC_EXTERNAL = 3'h0,
    SRC_RC_4MHZ = 3'h1,
    SRC_RC_8MHZ = 3'h2,
    SRC_WATCHDOG = 3'h3,
    SRC_CRYSTAL = 3'h4
  } source_t;

  // indices of the oscillator tick lines and the wake pin lines
  localparam int OSC_EXTERNAL = 0;
  localparam int OSC_RC_4MHZ = 1;
  localparam int OSC_RC_8MHZ = 2;
  localparam int OSC_WATCHDOG = 3;
  localparam int OSC_CRYSTAL = 4;
  localparam int PIN_EXT_INT = 5;
  localparam int PIN_SERIAL_START = 6;
  localparam int PIN_COUNT = 7;

  // sleep modes
  localparam logic [1:0] SLEEP_IDLE = 2'h0;
  localparam logic [1:0] SLEEP_POWER_DOWN = 2'h1;
  localparam logic [1:0] SLEEP_STANDBY = 2'h2;

  // controller states, one-hot
  typedef enum logic [6:0] {
    ST_CAPTURE = 7'h01,
    ST_OSC_START = 7'h02,
    ST_RESET_CK = 7'h04,
    ST_RESET_WDT = 7'h08,
    ST_RUN = 7'h10,
    ST_SLEEP = 7'h20,
    ST_WAKE_START = 7'h40
  } state_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // gated clock enables
  typedef struct packed {
    logic program_memory_clock;
    logic peripheral_clock;
    logic core_clock;
  } gate_t;

endpackage : clock_ctrl_pkg

// *** core/pin_sync.sv ***
// three-stage synchroniser with glitch filter and rising-edge pulse per line
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous lines
  input wire logic [WIDTH-1:0] pin_in,
  // filtered level and one-cycle rising pulse
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] rise;
  } sync_state_t;

  sync_state_t sync_reg;
  sync_state_t sync_next;

  // a change counts only once the second and third stage agree
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = pin_in;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (sync_reg.s2[i] == sync_reg.s3[i]) begin
        sync_next.lvl[i] = sync_reg.s3[i];
      end
    end
    sync_next.rise = sync_next.lvl & ~sync_reg.lvl;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign level = sync_reg.lvl;
  assign rise = sync_reg.rise;

endmodule : pin_sync

// *** core/clock_source_select_startup.sv ***
// clock source selection, start-up timing and gated clock distribution with apb registers
//
// Functional notes
// - sleep modes gate off clock enables of modules they do not use.
// - core clock stopped means the core performs no operations.
// - timers run on peripheral clock; external interrupts detected without it.
// - serial start condition detected while peripheral clock is stopped.
// - program memory clock follows the core clock.
// - four-bit source select decodes to external, rc4, rc8, watchdog, crystal.
// - option bit one means unprogrammed, zero means programmed.
// - wake from power-down counts start-up cycles of selected source first.
// - reset adds no delay or a 4096 or 65536 watchdog cycle delay.
// - delivered setting: source 0010, start-up 10, divide by eight programmed.
// - crystal mode upper three select bits choose the amplifier range.
// - crystal start-up table with lowest select bit zero.
// - crystal start-up table with lowest select bit one.
// - selected source feeds core, peripheral and program memory domains.
// - rc and external: 6 cycles wake; reset adds 14 cycles plus delay.
// - divide-by-eight option divides the clock by eight from start-up.
`timescale 1ns/1ps
module clock_source_select_startup #(
  parameter int STARTUP_16K_CK = clock_ctrl_pkg::STARTUP_16K_CK_DEFAULT,
  parameter int WDT_SHORT_CYCLES = clock_ctrl_pkg::WDT_SHORT_CYCLES_DEFAULT,
  parameter int WDT_LONG_CYCLES = clock_ctrl_pkg::WDT_LONG_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire clock_ctrl_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nonvolatile option bits
  input wire clock_ctrl_pkg::option_t option_bits,
  // oscillator outputs, one per source
  input wire logic osc_external,
  input wire logic osc_rc_4mhz,
  input wire logic osc_rc_8mhz,
  input wire logic osc_watchdog,
  input wire logic osc_crystal,
  // asynchronous wake sources
  input wire logic ext_int_pin,
  input wire logic serial_start_pin,
  // distributed clock enables and status
  output clock_ctrl_pkg::gate_t clock_enable,
  output logic oscillator_enable,
  output logic [2:0] crystal_range_select,
  output logic async_detect_arm
);

  typedef struct packed {
    clock_ctrl_pkg::state_t state;
    clock_ctrl_pkg::option_t opt;
    logic [16:0] cnt;
    logic [2:0] div_cnt;
    logic [1:0] sleep_mode;
    logic sleep_enable;
    logic [1:0] wake_flags;
    logic [31:0] rdata;
    clock_ctrl_pkg::gate_t gate;
  } ctrl_state_t;

  ctrl_state_t ctrl_reg;
  ctrl_state_t ctrl_next;

  logic [clock_ctrl_pkg::PIN_COUNT-1:0] pin_level;
  logic [clock_ctrl_pkg::PIN_COUNT-1:0] pin_rise;
  clock_ctrl_pkg::source_t source;
  logic is_crystal;
  logic src_tick;
  logic wdt_tick;
  logic sys_tick;
  logic access;
  logic setup;
  logic mapped;
  logic reserved_start;
  logic [16:0] startup_target;
  logic [16:0] reset_target;

  // source decode from the four select bits, raw bit values as programmed
  function automatic clock_ctrl_pkg::source_t decode_source(input logic [3:0] sel);
    clock_ctrl_pkg::source_t s;
    s = clock_ctrl_pkg::SRC_CRYSTAL;
    if (sel[3] == 1'b0) begin
      case (sel[2:1])
        2'h0: s = clock_ctrl_pkg::SRC_EXTERNAL;
        2'h1: s = clock_ctrl_pkg::SRC_RC_4MHZ;
        2'h2: s = clock_ctrl_pkg::SRC_RC_8MHZ;
        default: s = clock_ctrl_pkg::SRC_WATCHDOG;
      endcase
    end
    return s;
  endfunction : decode_source

  // start-up cycles of the selected source, used after power-down and reset
  function automatic logic [16:0] startup_cycles(input clock_ctrl_pkg::option_t o,
                                                 input logic xtal);
    logic [16:0] c;
    c = clock_ctrl_pkg::STARTUP_SHORT_CK;
    if (xtal) begin
      case ({o.clock_source_select[0], o.startup_time_select})
        3'h0, 3'h1: c = clock_ctrl_pkg::STARTUP_258_CK;
        3'h2, 3'h3: c = clock_ctrl_pkg::STARTUP_1K_CK;
        3'h4: c = clock_ctrl_pkg::STARTUP_1K_CK;
        default: c = 17'(STARTUP_16K_CK);
      endcase
    end
    return c;
  endfunction : startup_cycles

  // extra watchdog cycles after reset; zero means the 14 cycles alone
  function automatic logic [16:0] reset_wdt_cycles(input clock_ctrl_pkg::option_t o,
                                                   input logic xtal);
    logic [16:0] c;
    c = 17'h00000;
    if (xtal) begin
      case ({o.clock_source_select[0], o.startup_time_select})
        3'h0, 3'h3, 3'h6: c = 17'(WDT_SHORT_CYCLES);
        3'h1, 3'h4, 3'h7: c = 17'(WDT_LONG_CYCLES);
        default: c = 17'h00000;
      endcase
    end else begin
      case (o.startup_time_select)
        2'h0: c = 17'h00000;
        2'h1: c = 17'(WDT_SHORT_CYCLES);
        default: c = 17'(WDT_LONG_CYCLES);
      endcase
    end
    return c;
  endfunction : reset_wdt_cycles

  // oscillator and wake pins come from outside the pclk domain
  pin_sync #(
    .WIDTH(clock_ctrl_pkg::PIN_COUNT)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({serial_start_pin, ext_int_pin, osc_crystal, osc_watchdog, osc_rc_8mhz,
             osc_rc_4mhz, osc_external}),
    .level(pin_level),
    .rise(pin_rise)
  );

  // decode of the caught option bits and source tick selection
  always_comb begin
    source = decode_source(ctrl_reg.opt.clock_source_select);
    is_crystal = (source == clock_ctrl_pkg::SRC_CRYSTAL);
    reserved_start = !is_crystal && (ctrl_reg.opt.startup_time_select == 2'h3);
    startup_target = startup_cycles(ctrl_reg.opt, is_crystal);
    reset_target = reset_wdt_cycles(ctrl_reg.opt, is_crystal);
    wdt_tick = pin_rise[clock_ctrl_pkg::OSC_WATCHDOG];
    case (source)
      clock_ctrl_pkg::SRC_EXTERNAL: src_tick = pin_rise[clock_ctrl_pkg::OSC_EXTERNAL];
      clock_ctrl_pkg::SRC_RC_4MHZ: src_tick = pin_rise[clock_ctrl_pkg::OSC_RC_4MHZ];
      clock_ctrl_pkg::SRC_RC_8MHZ: src_tick = pin_rise[clock_ctrl_pkg::OSC_RC_8MHZ];
      clock_ctrl_pkg::SRC_WATCHDOG: src_tick = pin_rise[clock_ctrl_pkg::OSC_WATCHDOG];
      default: src_tick = pin_rise[clock_ctrl_pkg::OSC_CRYSTAL];
    endcase
    // programmed means zero: divide the system clock by eight
    if (ctrl_reg.opt.divide_by_eight_option == 1'b0) begin
      sys_tick = src_tick && (ctrl_reg.div_cnt == clock_ctrl_pkg::DIV8_LAST);
    end else begin
      sys_tick = src_tick;
    end
  end

  // apb decode
  always_comb begin
    access = apb_req.psel && apb_req.penable;
    setup = apb_req.psel && !apb_req.penable;
    case (apb_req.paddr)
      clock_ctrl_pkg::ADDR_OPTION_STATUS,
      clock_ctrl_pkg::ADDR_SLEEP_CTRL,
      clock_ctrl_pkg::ADDR_CLOCK_STATUS,
      clock_ctrl_pkg::ADDR_WAKE_FLAGS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // next state of the whole controller
  always_comb begin
    logic [1:0] wake_set;
    logic [1:0] wake_clr;
    logic wake_any;
    logic wr;
    wake_set = {pin_rise[clock_ctrl_pkg::PIN_SERIAL_START],
                pin_rise[clock_ctrl_pkg::PIN_EXT_INT]};
    wake_clr = 2'h0;
    wake_any = |wake_set;
    wr = access && apb_req.pwrite;
    ctrl_next = ctrl_reg;

    // divider runs on every tick of the selected source
    if (src_tick) begin
      ctrl_next.div_cnt = 3'(ctrl_reg.div_cnt + 3'h1);
    end

    // register writes
    if (wr && apb_req.paddr == clock_ctrl_pkg::ADDR_SLEEP_CTRL) begin
      ctrl_next.sleep_mode = apb_req.pwdata[clock_ctrl_pkg::SLEEP_MODE_LSB +: 2];
      ctrl_next.sleep_enable = apb_req.pwdata[clock_ctrl_pkg::SLEEP_ENABLE_BIT];
    end
    if (wr && apb_req.paddr == clock_ctrl_pkg::ADDR_WAKE_FLAGS) begin
      wake_clr = apb_req.pwdata[1:0];
    end
    // a wake event in the clearing cycle is kept
    ctrl_next.wake_flags = (ctrl_reg.wake_flags & ~wake_clr) | wake_set;

    // sequencing
    case (ctrl_reg.state)
      clock_ctrl_pkg::ST_CAPTURE: begin
        ctrl_next.opt = option_bits;
        ctrl_next.div_cnt = 3'h0;
        ctrl_next.cnt = startup_cycles(option_bits,
                                       decode_source(option_bits.clock_source_select) ==
                                       clock_ctrl_pkg::SRC_CRYSTAL);
        ctrl_next.state = clock_ctrl_pkg::ST_OSC_START;
      end
      clock_ctrl_pkg::ST_OSC_START: begin
        if (src_tick) begin
          ctrl_next.cnt = 17'(ctrl_reg.cnt - 17'h1);
          if (ctrl_reg.cnt == 17'h1) begin
            ctrl_next.cnt = clock_ctrl_pkg::RESET_EXTRA_CK;
            ctrl_next.state = clock_ctrl_pkg::ST_RESET_CK;
          end
        end
      end
      clock_ctrl_pkg::ST_RESET_CK: begin
        if (src_tick) begin
          ctrl_next.cnt = 17'(ctrl_reg.cnt - 17'h1);
          if (ctrl_reg.cnt == 17'h1) begin
            ctrl_next.cnt = reset_target;
            ctrl_next.div_cnt = 3'h0;
            if (reset_target == 17'h0) begin
              ctrl_next.state = clock_ctrl_pkg::ST_RUN;
            end else begin
              ctrl_next.state = clock_ctrl_pkg::ST_RESET_WDT;
            end
          end
        end
      end
      clock_ctrl_pkg::ST_RESET_WDT: begin
        if (wdt_tick) begin
          ctrl_next.cnt = 17'(ctrl_reg.cnt - 17'h1);
          if (ctrl_reg.cnt == 17'h1) begin
            ctrl_next.div_cnt = 3'h0;
            ctrl_next.state = clock_ctrl_pkg::ST_RUN;
          end
        end
      end
      clock_ctrl_pkg::ST_RUN: begin
        if (wr && apb_req.paddr == clock_ctrl_pkg::ADDR_SLEEP_CTRL &&
            apb_req.pwdata[clock_ctrl_pkg::SLEEP_GO_BIT] &&
            apb_req.pwdata[clock_ctrl_pkg::SLEEP_ENABLE_BIT]) begin
          ctrl_next.state = clock_ctrl_pkg::ST_SLEEP;
        end
      end
      clock_ctrl_pkg::ST_SLEEP: begin
        if (wake_any) begin
          if (ctrl_reg.sleep_mode == clock_ctrl_pkg::SLEEP_POWER_DOWN) begin
            ctrl_next.cnt = startup_target;
            ctrl_next.state = clock_ctrl_pkg::ST_WAKE_START;
          end else if (ctrl_reg.sleep_mode == clock_ctrl_pkg::SLEEP_STANDBY) begin
            ctrl_next.cnt = clock_ctrl_pkg::STARTUP_SHORT_CK;
            ctrl_next.state = clock_ctrl_pkg::ST_WAKE_START;
          end else begin
            ctrl_next.state = clock_ctrl_pkg::ST_RUN;
          end
        end
      end
      clock_ctrl_pkg::ST_WAKE_START: begin
        if (src_tick) begin
          ctrl_next.cnt = 17'(ctrl_reg.cnt - 17'h1);
          if (ctrl_reg.cnt == 17'h1) begin
            ctrl_next.div_cnt = 3'h0;
            ctrl_next.state = clock_ctrl_pkg::ST_RUN;
          end
        end
      end
      default: begin
        ctrl_next.state = clock_ctrl_pkg::ST_CAPTURE;
      end
    endcase

    // clock gating per state and sleep mode
    ctrl_next.gate = '0;
    if (ctrl_reg.state == clock_ctrl_pkg::ST_RUN) begin
      ctrl_next.gate.core_clock = sys_tick;
      ctrl_next.gate.peripheral_clock = sys_tick;
      ctrl_next.gate.program_memory_clock = sys_tick;
    end else if (ctrl_reg.state == clock_ctrl_pkg::ST_SLEEP &&
                 ctrl_reg.sleep_mode != clock_ctrl_pkg::SLEEP_POWER_DOWN &&
                 ctrl_reg.sleep_mode != clock_ctrl_pkg::SLEEP_STANDBY) begin
      ctrl_next.gate.peripheral_clock = sys_tick;
    end

    // read data is prepared in the setup phase, held through the access phase
    if (setup && !apb_req.pwrite) begin
      ctrl_next.rdata = 32'h0;
      case (apb_req.paddr)
        clock_ctrl_pkg::ADDR_OPTION_STATUS: ctrl_next.rdata[6:0] = ctrl_reg.opt;
        clock_ctrl_pkg::ADDR_SLEEP_CTRL: begin
          ctrl_next.rdata[clock_ctrl_pkg::SLEEP_MODE_LSB +: 2] = ctrl_reg.sleep_mode;
          ctrl_next.rdata[clock_ctrl_pkg::SLEEP_ENABLE_BIT] = ctrl_reg.sleep_enable;
        end
        clock_ctrl_pkg::ADDR_CLOCK_STATUS: begin
          ctrl_next.rdata[clock_ctrl_pkg::STATUS_STATE_LSB +: 7] = ctrl_reg.state;
          ctrl_next.rdata[clock_ctrl_pkg::STATUS_GATE_LSB +: 3] = ctrl_reg.gate;
          ctrl_next.rdata[clock_ctrl_pkg::STATUS_ASYNC_ARM_BIT] = async_detect_arm;
          ctrl_next.rdata[clock_ctrl_pkg::STATUS_RESERVED_START_BIT] = reserved_start;
          ctrl_next.rdata[clock_ctrl_pkg::STATUS_SOURCE_LSB +: 3] = source;
        end
        clock_ctrl_pkg::ADDR_WAKE_FLAGS: ctrl_next.rdata[1:0] = ctrl_reg.wake_flags;
        default: ctrl_next.rdata = 32'h0;
      endcase
    end
  end

  // state register; options reset to the delivered setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '{state: clock_ctrl_pkg::ST_CAPTURE,
                    opt: clock_ctrl_pkg::DELIVERED_OPTIONS,
                    cnt: 17'h0,
                    div_cnt: 3'h0,
                    sleep_mode: clock_ctrl_pkg::SLEEP_IDLE,
                    sleep_enable: 1'b0,
                    wake_flags: 2'h0,
                    rdata: 32'h0,
                    gate: '0};
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // outputs
  assign prdata = ctrl_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign clock_enable = ctrl_reg.gate;
  // oscillator stops only in power-down sleep
  assign oscillator_enable = !(ctrl_reg.state == clock_ctrl_pkg::ST_SLEEP &&
                               ctrl_reg.sleep_mode == clock_ctrl_pkg::SLEEP_POWER_DOWN);
  // amplifier range for crystal mode; zero when another source is chosen
  assign crystal_range_select = is_crystal ? ctrl_reg.opt.clock_source_select[3:1]
                                           : 3'h0;
  // asynchronous detectors armed in every state other than run, idle sleep included
  assign async_detect_arm = (ctrl_reg.state != clock_ctrl_pkg::ST_RUN);

endmodule : clock_source_select_startup

// *** tb/clock_ctrl_props.sv ***
// concurrent checks on the clock controller ports
`timescale 1ns/1ps
module clock_ctrl_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire clock_ctrl_pkg::apb_req_t apb_req,
  input wire logic pready,
  input wire logic pslverr,
  // options
  input wire clock_ctrl_pkg::option_t option_bits,
  // outputs
  input wire clock_ctrl_pkg::gate_t clock_enable,
  input wire logic oscillator_enable,
  input wire logic [2:0] crystal_range_select,
  input wire logic async_detect_arm
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cap;
  clock_ctrl_pkg::option_t copt;
  // copy of the options as the design catches them after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= 1'b0;
      copt <= '0;
    end else if (!cap) begin
      cap <= 1'b1;
      copt <= option_bits;
    end
  end
  // assertions
  pm_follow_a: assert property (clock_enable.program_memory_clock ==
    clock_enable.core_clock)
    else $error("program memory enable differs from core enable");
  core_run_a: assert property (clock_enable.core_clock |->
    !async_detect_arm || !$past(async_detect_arm))
    else $error("core enable outside run");
  pulse_one_a: assert property (clock_enable.core_clock |=> !clock_enable.core_clock [*4])
    else $error("core enable pulses too close");
  div_gap_a: assert property (clock_enable.core_clock && cap
    && !copt.divide_by_eight_option |=> !clock_enable.core_clock [*8])
    else $error("divided enable too frequent");
  range_hold_a: assert property (cap |-> crystal_range_select ==
    (copt.clock_source_select[3] ? copt.clock_source_select[3:1] : 3'h0))
    else $error("crystal range wrong");
  osc_off_a: assert property (!oscillator_enable && !$past(oscillator_enable)
    |-> clock_enable == '0 && async_detect_arm)
    else $error("enables while oscillator off");
  sleep_periph_a: assert property (async_detect_arm && $past(async_detect_arm)
    && clock_enable.peripheral_clock |-> oscillator_enable)
    else $error("peripheral enable in power-down");
  start_quiet_a: assert property ($rose(presetn) |-> (clock_enable == '0) [*8])
    else $error("enable right after reset");
  apb_ready_a: assert property (apb_req.psel && apb_req.penable |-> pready)
    else $error("no ready in access");
  apb_err_a: assert property (pslverr == (apb_req.psel && apb_req.penable &&
    !(apb_req.paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})))
    else $error("slave error wrong");
  // main scenarios
  run_c: cover property ($fell(async_detect_arm));
  core_c: cover property (clock_enable.core_clock);
  pd_c: cover property (!oscillator_enable);
endmodule : clock_ctrl_props

bind clock_source_select_startup clock_ctrl_props u_props (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .pready(pready), .pslverr(pslverr), .option_bits(option_bits),
  .clock_enable(clock_enable), .oscillator_enable(oscillator_enable),
  .crystal_range_select(crystal_range_select), .async_detect_arm(async_detect_arm));

// *** tb/osc_model.sv ***
// oscillator source that holds its level while its enable is low
`timescale 1ns/1ps
module osc_model #(
  parameter int HALF = 3
) (
  // enable from the controller
  input wire logic run,
  // oscillator line
  output logic osc
);
  // resonator-like source, no start-up settling modelled
  initial begin
    osc = 1'b0;
    forever begin
      #(HALF * 10.0 + 1.3);
      if (run) osc = ~osc;
    end
  end
endmodule : osc_model

// *** tb/tb_clock_source_select_startup.sv ***
// self-checking bench for the clock source and start-up controller
`timescale 1ns/1ps
module tb_clock_source_select_startup;
  localparam int K16 = 20;
  localparam int WS = 8;
  localparam int WL = 16;
  localparam int HALF [5] = '{3, 4, 5, 6, 3};
  logic pclk, presetn, pready, pslverr, ext_pin, ser_pin, osc_en, arm, er;
  logic [31:0] prdata, rd;
  logic [4:0] osc;
  logic [2:0] xrange;
  clock_ctrl_pkg::apb_req_t req;
  clock_ctrl_pkg::option_t opt;
  clock_ctrl_pkg::gate_t ce;
  int n_mismatch, total_checks;

  clock_source_select_startup #(.STARTUP_16K_CK(K16), .WDT_SHORT_CYCLES(WS),
    .WDT_LONG_CYCLES(WL)) dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .option_bits(opt),
    .osc_external(osc[0]), .osc_rc_4mhz(osc[1]), .osc_rc_8mhz(osc[2]),
    .osc_watchdog(osc[3]), .osc_crystal(osc[4]), .ext_int_pin(ext_pin),
    .serial_start_pin(ser_pin), .clock_enable(ce), .oscillator_enable(osc_en),
    .crystal_range_select(xrange), .async_detect_arm(arm));

  // oscillators; the watchdog one never stops
  for (genvar g = 0; g < 5; g++) begin : g_osc
    osc_model #(.HALF(HALF[g])) u_osc (.run(g == 3 ? 1'b1 : osc_en), .osc(osc[g]));
  end

  // system clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task end_sim;
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  // one apb transfer, held until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_sim;
    end
    rd = prdata;
    er = pslverr;
    req <= '0;
  endtask : apb

  // waits for run and checks the elapsed time in ns
  task wait_run(input real lo, input real hi, input string msg);
    real t0;
    int n;
    t0 = $realtime;
    n = 0;
    while (arm !== 1'b0 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (arm !== 1'b0) begin
      n_mismatch++;
      end_sim;
    end
    chk($realtime - t0 >= lo && $realtime - t0 <= hi, msg);
  endtask : wait_run

  // reference model: source ticks of start-up, reset watchdog ticks, source index
  function automatic int n_start(clock_ctrl_pkg::option_t o);
    int c;
    c = int'({o.clock_source_select[0], o.startup_time_select});
    if (!o.clock_source_select[3]) return 6;
    if (c < 2) return 258;
    if (c < 5) return 1024;
    return K16;
  endfunction : n_start

  function automatic int n_wdt(clock_ctrl_pkg::option_t o);
    int c;
    c = int'({o.clock_source_select[0], o.startup_time_select}) % 3;
    if (!o.clock_source_select[3])
      c = o.startup_time_select == 2'h0 ? 2 : (o.startup_time_select == 2'h1 ? 0 : 1);
    return c == 0 ? WS : (c == 1 ? WL : 0);
  endfunction : n_wdt

  function automatic int src(clock_ctrl_pkg::option_t o);
    return o.clock_source_select[3] ? 4 : int'(o.clock_source_select[2:1]);
  endfunction : src

  initial begin
    clock_ctrl_pkg::option_t o;
    real ps, pw, ex;
    int i, m, n, ns, nw, cc, pc;
    n_mismatch = 0;
    total_checks = 0;
    presetn = 1'b0;
    req = '0;
    opt = clock_ctrl_pkg::DELIVERED_OPTIONS;
    ext_pin = 1'b0;
    ser_pin = 1'b0;
    void'($urandom(32'h14608f27));
    // every source code with random start-up and divide option, code 2 with the delivered setting, code 8 again with fixed options
    for (i = 0; i < 17; i++) begin
      o = {1'($urandom), 2'($urandom), 4'(i)};
      if (i == 2) o = clock_ctrl_pkg::DELIVERED_OPTIONS;
      if (i == 16) o = {1'b1, 2'b00, 4'h8};
      @(posedge pclk);
      presetn <= 1'b0;
      opt <= o;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      ns = n_start(o) + 14;
      nw = n_wdt(o);
      ps = 2.0 * (HALF[src(o)] * 10.0 + 1.3);
      pw = 2.0 * (HALF[3] * 10.0 + 1.3);
      wait_run((ns - 1) * ps + (nw > 0 ? (nw - 1) * pw : 0.0), ns * ps + nw * pw + 150.0,
        "start-up time");
      opt <= ~o;
      apb(1'b1, clock_ctrl_pkg::ADDR_OPTION_STATUS, 32'h0);
      apb(1'b0, clock_ctrl_pkg::ADDR_OPTION_STATUS, 32'h0);
      chk(rd[6:0] === o, "captured options");
      apb(1'b0, clock_ctrl_pkg::ADDR_CLOCK_STATUS, 32'h0);
      chk(rd[18:16] === 3'(src(o)), "source field");
      chk(rd[6:0] === 7'h10 && rd[12] === (!o.clock_source_select[3] &&
        o.startup_time_select == 2'h3), "run state and reserved flag");
      chk(xrange === (o.clock_source_select[3] ? o.clock_source_select[3:1] : 3'h0),
        "crystal range");
      // spacing of system ticks
      n = 0;
      while (ce.core_clock !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      @(posedge pclk);
      n = 1;
      while (ce.core_clock !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      ex = ps / 10.0 * (o.divide_by_eight_option ? 1 : 8);
      chk(n > ex - 2.5 && n < ex + 2.5, "tick spacing");
    end
    apb(1'b0, 8'h10, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b1, clock_ctrl_pkg::ADDR_SLEEP_CTRL, 32'h3);
    apb(1'b0, clock_ctrl_pkg::ADDR_SLEEP_CTRL, 32'h0);
    chk(rd[2:0] === 3'h3, "sleep control readback");
    // idle, power-down and standby, each woken by an asynchronous pin
    for (m = 0; m < 3; m++) begin
      apb(1'b1, clock_ctrl_pkg::ADDR_SLEEP_CTRL, 32'h104 | m);
      repeat (4) @(posedge pclk);
      chk(arm === 1'b1 && osc_en === (m != 1), "sleep entry");
      cc = 0;
      pc = 0;
      repeat (60) begin
        @(posedge pclk);
        cc += int'(ce.core_clock === 1'b1);
        pc += int'(ce.peripheral_clock === 1'b1);
      end
      chk(cc == 0 && (pc > 0) == (m == 0), "sleep gating");
      if (m == 1) ser_pin <= 1'b1;
      else ext_pin <= 1'b1;
      ns = m == 0 ? 0 : (m == 1 ? n_start(o) : 6);
      wait_run(ns > 0 ? (ns - 1) * ps : 0.0, (ns + 1) * ps + 150.0, "wake time");
      ext_pin <= 1'b0;
      ser_pin <= 1'b0;
      apb(1'b0, clock_ctrl_pkg::ADDR_WAKE_FLAGS, 32'h0);
      chk(rd[1:0] === (m == 1 ? 2'h2 : 2'h1), "wake flag");
      apb(1'b1, clock_ctrl_pkg::ADDR_WAKE_FLAGS, 32'h3);
    end
    apb(1'b0, clock_ctrl_pkg::ADDR_WAKE_FLAGS, 32'h0);
    chk(rd[1:0] === 2'h0, "wake flags cleared");
    end_sim;
  end
endmodule : tb_clock_source_select_startup
